// File: nvc_pkg.sv
// Notes on behaviour
// R1 - software commands use only chip-select-timed reads
// R2 - six reads to fixed addresses, fixed order
// R3 - write strobe high throughout command sequence
// R4 - device acts within 70 us after sixth read
// R5 - bus locked out during operation; recall 50 us
// R6 - store skipped when no write since last
// R7 - hardware store pin low at least 15 ns
// R8 - device drains cycles 1 to 70 us
// R9 - store pin high during ordinary cycles
// R10 - out-of-order read aborts partial command sequence
//
// Purpose: constants and state types of the nonvolatile SRAM host controller
// Assumes: 20 MHz controller clock
// Notes:   command address list must match the attached part
package nvc_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CNT_W = 18;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int SYNC_STAGES = 2;

   // printed times
   localparam int READ_ACCESS_NS = 45;
   localparam int WRITE_PULSE_NS = 30;
   localparam int STORE_PULSE_MIN_NS = 15;
   localparam int SOFT_CMD_LATENCY_US = 70;
   localparam int RECALL_DURATION_US = 50;
   localparam int CYCLE_DRAIN_TIME_MAX_US = 70;
   localparam int STORE_DURATION_US = 12500;

   // derived cycle counts
   localparam int ACC_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_ACT_CYC = ACC_CYC + SYNC_STAGES + 1;
   localparam int WR_ACT_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (STORE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFT_CYC = (SOFT_CMD_LATENCY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECALL_CYC = (RECALL_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DRAIN_CYC =
      (CYCLE_DRAIN_TIME_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STORE_CYC_DEF = (STORE_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // six-read command sequence; values must be set for the attached part
   localparam int SEQ_LEN = 6;
   localparam logic [ADDR_W-1:0] SEQ_ADDR [SEQ_LEN] = '{
      17'h00001, 17'h00002, 17'h00003, 17'h00004, 17'h00005, 17'h00006};
   localparam logic [ADDR_W-1:0] SEQ_LAST_STORE = 17'h00007;
   localparam logic [ADDR_W-1:0] SEQ_LAST_RECALL = 17'h00008;

   // user operation codes
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_SOFT_STORE = 3'h2;
   localparam logic [2:0] OP_SOFT_RECALL = 3'h3;
   localparam logic [2:0] OP_HW_STORE = 3'h4;

   typedef enum logic [2:0] {
      NVC_IDLE = 3'h0,
      NVC_ACT = 3'h1,
      NVC_GAP = 3'h3,
      NVC_WCMD = 3'h2,
      NVC_WOP = 3'h6,
      NVC_HPUL = 3'h7,
      NVC_HWAIT = 3'h5
   } nvc_state_e;

   typedef struct packed {
      nvc_state_e st;
      logic [CNT_W-1:0] cnt;
      logic [2:0] idx;
      logic [2:0] op;
      logic phase;
      logic dirty;
      logic skip;
      logic rsp;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe_n;
      logic store_pin_oe_n;
   } nvc_state_s;
endpackage

// File: nvc_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: single clock domain, synchronous reset
// Notes:   only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none
module nvc_sync
   #(parameter int W = 1,
     parameter logic [W-1:0] RST_VAL = '0)
   (
   // clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
   );
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } nvc_sync_s;

   nvc_sync_s q_r;
   nvc_sync_s q_nxt;

   always_comb
   begin
      q_nxt.s1 = d_in;
      q_nxt.s2 = q_r.s1;
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         q_r <= {RST_VAL, RST_VAL};
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign q_out = q_r.s2;
endmodule // nvc_sync
`default_nettype wire

// File: nvc_host.sv
// Purpose: host controller for nonvolatile SRAM reads, writes, store and recall
// Assumes: one request at a time; pin inputs synchronised here
// Notes:   bus stays idle while a nonvolatile operation runs
`timescale 1ns/1ns
`default_nettype none
module nvc_host
   import nvc_pkg::*;
   #(parameter int STORE_CYC = STORE_CYC_DEF)
   (
   // clock and reset
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // user requests
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic [2:0] req_op_in,
   input wire logic [ADDR_W-1:0] req_addr_in,
   input wire logic [DATA_W-1:0] req_wdata_in,
   // user answers
   output logic rsp_valid_out,
   output logic [DATA_W-1:0] rsp_rdata_out,
   output logic busy_out,
   output logic store_skipped_out,
   // sram pins
   output logic [ADDR_W-1:0] sram_addr_out,
   output logic sram_ce_n_out,
   output logic sram_oe_n_out,
   output logic sram_we_n_out,
   input wire logic [DATA_W-1:0] sram_dq_in,
   output logic [DATA_W-1:0] sram_dq_out,
   output logic sram_dq_oe_n_out,
   // hardware store pin, open drain
   input wire logic hw_store_busy_n_in,
   output logic hw_store_busy_n_out,
   output logic hw_store_busy_n_oe_n_out
   );
   nvc_state_s q_r;
   nvc_state_s q_nxt;
   logic [DATA_W-1:0] dq_sync;
   logic store_pin_sync;

   localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_ACT_CYC - 1);
   localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_ACT_CYC - 1);
   localparam logic [CNT_W-1:0] PUL_LOAD = CNT_W'(PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] SOFT_LOAD = CNT_W'(SOFT_CYC - 1);
   localparam logic [CNT_W-1:0] REC_LOAD = CNT_W'(RECALL_CYC - 1);
   // margin covers the synchroniser lag on the store pin
   localparam logic [CNT_W-1:0] DRN_LOAD = CNT_W'(DRAIN_CYC + SYNC_STAGES);
   localparam logic [CNT_W-1:0] STO_LOAD = CNT_W'(STORE_CYC - 1);

   // address of read number i of a command sequence
   function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] i, input logic [2:0] op);
      logic [ADDR_W-1:0] a;
      a = SEQ_ADDR[0];
      if (i == 3'(SEQ_LEN - 1))
      begin
         a = (op == OP_SOFT_STORE) ? SEQ_LAST_STORE : SEQ_LAST_RECALL;
      end
      else if (i < 3'(SEQ_LEN))
      begin
         a = SEQ_ADDR[i];
      end
      return a;
   endfunction

   nvc_sync #(.W(DATA_W), .RST_VAL('0)) u_dq_sync (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .d_in(sram_dq_in),
      .q_out(dq_sync)
   );

   nvc_sync #(.W(1), .RST_VAL(1'b1)) u_store_pin_sync (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .d_in(hw_store_busy_n_in),
      .q_out(store_pin_sync)
   );

   always_comb
   begin
      q_nxt = q_r;
      q_nxt.rsp = 1'b0;
      case (q_r.st)
         NVC_IDLE:
         begin
            if (req_valid_in)
            begin
               q_nxt.op = req_op_in;
               q_nxt.skip = 1'b0;
               q_nxt.idx = 3'h0;
               q_nxt.phase = 1'b0;
               if (req_op_in == OP_HW_STORE)
               begin
                  q_nxt.store_pin_oe_n = 1'b0; // R7 R9
                  q_nxt.cnt = PUL_LOAD;
                  q_nxt.st = NVC_HPUL;
               end
               else if (req_op_in == OP_WRITE)
               begin
                  q_nxt.addr = req_addr_in;
                  q_nxt.wdata = req_wdata_in;
                  q_nxt.ce_n = 1'b0;
                  q_nxt.we_n = 1'b0;
                  q_nxt.dq_oe_n = 1'b0;
                  q_nxt.dirty = 1'b1; // R6
                  q_nxt.cnt = WR_LOAD;
                  q_nxt.st = NVC_ACT;
               end
               else
               begin
                  // reads and first read of a command sequence R1 R3
                  q_nxt.addr = (req_op_in == OP_READ) ? req_addr_in : seq_addr(3'h0, req_op_in);
                  q_nxt.ce_n = 1'b0;
                  q_nxt.oe_n = 1'b0;
                  q_nxt.cnt = RD_LOAD;
                  q_nxt.st = NVC_ACT;
               end
            end
         end
         NVC_ACT:
         begin
            if (q_r.cnt == '0)
            begin
               if (q_r.op == OP_READ)
               begin
                  q_nxt.rdata = dq_sync;
               end
               q_nxt.ce_n = 1'b1;
               q_nxt.oe_n = 1'b1;
               q_nxt.we_n = 1'b1;
               q_nxt.dq_oe_n = 1'b1;
               q_nxt.st = NVC_GAP;
            end
            else
            begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
         end
         NVC_GAP:
         begin
            if (q_r.op == OP_SOFT_STORE || q_r.op == OP_SOFT_RECALL)
            begin
               if (q_r.idx == 3'(SEQ_LEN - 1))
               begin
                  q_nxt.cnt = SOFT_LOAD; // R4
                  q_nxt.st = NVC_WCMD;
               end
               else
               begin
                  // next read follows straight on, in list order R2 R10
                  q_nxt.idx = q_r.idx + 1'b1;
                  q_nxt.addr = seq_addr(q_r.idx + 1'b1, q_r.op);
                  q_nxt.ce_n = 1'b0;
                  q_nxt.oe_n = 1'b0;
                  q_nxt.cnt = RD_LOAD;
                  q_nxt.st = NVC_ACT;
               end
            end
            else
            begin
               q_nxt.rsp = 1'b1;
               q_nxt.st = NVC_IDLE;
            end
         end
         NVC_WCMD:
         begin
            if (q_r.cnt != '0)
            begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
            else if (q_r.op == OP_SOFT_RECALL)
            begin
               q_nxt.cnt = REC_LOAD; // R5
               q_nxt.dirty = 1'b0;
               q_nxt.st = NVC_WOP;
            end
            else if (q_r.dirty)
            begin
               q_nxt.cnt = STO_LOAD;
               q_nxt.dirty = 1'b0;
               q_nxt.st = NVC_WOP;
            end
            else
            begin
               q_nxt.skip = 1'b1; // R6
               q_nxt.rsp = 1'b1;
               q_nxt.st = NVC_IDLE;
            end
         end
         NVC_WOP:
         begin
            // bus held idle until the operation is over R5
            if (q_r.cnt != '0)
            begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
            else
            begin
               q_nxt.rsp = 1'b1;
               q_nxt.st = NVC_IDLE;
            end
         end
         NVC_HPUL:
         begin
            if (q_r.cnt != '0)
            begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
            else
            begin
               q_nxt.store_pin_oe_n = 1'b1;
               q_nxt.cnt = DRN_LOAD; // R8
               q_nxt.st = NVC_HWAIT;
            end
         end
         NVC_HWAIT:
         begin
            // drain window first, then poll busy pin with a store timeout
            if (q_r.cnt != '0 && !(q_r.phase && store_pin_sync))
            begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
            else if (q_r.cnt == '0 && !q_r.phase && !store_pin_sync)
            begin
               q_nxt.phase = 1'b1;
               q_nxt.cnt = STO_LOAD;
            end
            else
            begin
               // skip decided at the end so that it rises together with rsp
               q_nxt.skip = ~q_r.dirty; // R6
               q_nxt.dirty = 1'b0;
               q_nxt.rsp = 1'b1;
               q_nxt.st = NVC_IDLE;
            end
         end
         default:
         begin
            q_nxt.st = NVC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         q_r <= '{st: NVC_IDLE, cnt: '0, idx: '0, op: '0, phase: 1'b0, dirty: 1'b1,
                  skip: 1'b0, rsp: 1'b0, addr: '0, wdata: '0, rdata: '0, ce_n: 1'b1,
                  oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1, store_pin_oe_n: 1'b1};
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign req_ready_out = (q_r.st == NVC_IDLE);
   assign rsp_valid_out = q_r.rsp;
   assign rsp_rdata_out = q_r.rdata;
   assign busy_out = (q_r.st != NVC_IDLE);
   assign store_skipped_out = q_r.skip;
   assign sram_addr_out = q_r.addr;
   assign sram_ce_n_out = q_r.ce_n;
   assign sram_oe_n_out = q_r.oe_n;
   assign sram_we_n_out = q_r.we_n;
   assign sram_dq_out = q_r.wdata;
   assign sram_dq_oe_n_out = q_r.dq_oe_n;
   assign hw_store_busy_n_out = 1'b0;
   assign hw_store_busy_n_oe_n_out = q_r.store_pin_oe_n;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   logic soft_op;
   assign soft_op = (q_r.op == OP_SOFT_STORE) || (q_r.op == OP_SOFT_RECALL);

   property p_soft_read_only;
      (soft_op && busy_out && !sram_ce_n_out) |-> !sram_oe_n_out;
   endproperty
   a_soft_read_only: assert property (p_soft_read_only) else $error("soft read not oe timed"); // R1

   property p_soft_addr;
      (soft_op && q_r.st == NVC_ACT) |-> sram_addr_out == seq_addr(q_r.idx, q_r.op);
   endproperty
   a_soft_addr: assert property (p_soft_addr) else $error("sequence address wrong"); // R2

   property p_we_high;
      (soft_op && busy_out) |-> sram_we_n_out;
   endproperty
   a_we_high: assert property (p_we_high) else $error("write strobe low in sequence"); // R3

   property p_six_reads;
      $rose(q_r.st == NVC_WCMD) |-> $past(q_r.idx) == 3'(SEQ_LEN - 1);
   endproperty
   a_six_reads: assert property (p_six_reads) else $error("sequence not six reads"); // R2

   sequence s_cmd_wait;
      (q_r.st == NVC_WCMD && sram_ce_n_out)[*8];
   endsequence
   property p_cmd_wait;
      $rose(q_r.st == NVC_WCMD) |-> s_cmd_wait;
   endproperty
   a_cmd_wait: assert property (p_cmd_wait) else $error("command wait cut short"); // R4

   property p_lockout;
      (q_r.st == NVC_WCMD || q_r.st == NVC_WOP || q_r.st == NVC_HWAIT)
         |-> sram_ce_n_out && !req_ready_out;
   endproperty
   a_lockout: assert property (p_lockout) else $error("bus used during operation"); // R5

   property p_skip;
      $rose(store_skipped_out) |-> !$past(q_r.dirty) && rsp_valid_out;
   endproperty
   a_skip: assert property (p_skip) else $error("skip reported after a write"); // R6

   property p_pulse;
      $fell(hw_store_busy_n_oe_n_out) |-> ##1 hw_store_busy_n_oe_n_out && sram_ce_n_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("store pulse width wrong"); // R7

   sequence s_drain;
      (sram_ce_n_out && q_r.st == NVC_HWAIT)[*8];
   endsequence
   property p_drain;
      $rose(hw_store_busy_n_oe_n_out) |-> s_drain;
   endproperty
   a_drain: assert property (p_drain) else $error("bus used in drain window"); // R8

   property p_pin_high;
      !sram_ce_n_out |-> hw_store_busy_n_oe_n_out;
   endproperty
   a_pin_high: assert property (p_pin_high) else $error("store pin low during cycle"); // R9
endmodule // nvc_host
`default_nettype wire

// File: nvc_dev_model.sv
// Purpose: behavioural nonvolatile SRAM with store, recall and busy pin
// Assumes: cycles framed by chip select; store pin wired with a pull-up
// Notes:   delays are parameters; errs counts host pin-protocol faults
`timescale 1ns/1ns
`default_nettype none
module nvc_dev_model
   import nvc_pkg::*;
   #(parameter int LAT_NS = 10000,
     parameter int RECALL_NS = 20000,
     parameter int STORE_NS = 2000,
     parameter int DRAIN_NS = 69000)
   (
   // sram pins
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   // store pin, wired level in, own pull out
   input wire logic store_pin_in,
   output logic store_pin_pull_out
   );
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] nv [2**ADDR_W];
   logic [DATA_W-1:0] last_r = 8'h00;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;
   logic cyc_wr;
   logic cyc_rd;
   logic hw_pend = 1'b0;
   logic dirty = 1'b0;
   logic busy = 1'b0;
   int idx = 0;
   int stores = 0;
   int recalls = 0;
   int errs = 0;
   time t_fall;

   initial
   begin
      foreach (mem[i]) mem[i] = 8'h00;
      foreach (nv[i]) nv[i] = 8'h00;
   end

   // released bus shows the inverse of the last byte, never a kind guess
   assign dq_out = (!ce_n_in && !oe_n_in && we_n_in && !busy) ? mem[addr_in] : ~last_r;
   assign store_pin_pull_out = busy;

   task automatic run_op(input bit rec);
      if (rec || dirty)
      begin
         busy = 1'b1;
         #(rec ? RECALL_NS : STORE_NS);
         if (rec)
         begin
            mem = nv;
            recalls++;
         end
         else
         begin
            nv = mem;
            stores++;
         end
         busy = 1'b0;
      end
      dirty = 1'b0;
   endtask

   task automatic soft_cmd(input bit rec);
      #(LAT_NS);
      run_op(rec);
   endtask

   task automatic hw_store();
      #(DRAIN_NS);
      run_op(1'b0);
   endtask

   always @(negedge ce_n_in)
   begin
      if (busy) errs++;
      #1;
      cyc_wr = !we_n_in;
      cyc_rd = !oe_n_in && we_n_in;
      cyc_addr = addr_in;
      cyc_data = dq_in;
   end

   always @(posedge ce_n_in)
   begin
      if (store_pin_in !== 1'b1) errs++;
      if (busy)
         idx = 0;
      else if (cyc_wr)
      begin
         mem[cyc_addr] = cyc_data;
         dirty = 1'b1;
         idx = 0;
      end
      else if (cyc_rd)
      begin
         last_r = mem[cyc_addr];
         if (idx == SEQ_LEN-1 && (cyc_addr == SEQ_LAST_STORE || cyc_addr == SEQ_LAST_RECALL))
         begin
            idx = 0;
            fork
               soft_cmd(cyc_addr == SEQ_LAST_RECALL);
            join_none
         end
         else if (idx < SEQ_LEN-1 && cyc_addr == SEQ_ADDR[idx])
            idx++;
         else
            idx = int'(cyc_addr == SEQ_ADDR[0]);
      end
   end

   always @(negedge store_pin_in)
      if (!busy)
      begin
         hw_pend = 1'b1;
         t_fall = $time;
      end

   always @(posedge store_pin_in)
      if (hw_pend)
      begin
         hw_pend = 1'b0;
         if ($time - t_fall < STORE_PULSE_MIN_NS) errs++;
         fork
            hw_store();
         join_none
      end
endmodule // nvc_dev_model
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the nonvolatile SRAM host controller
// Assumes: device model on the pins, short store count
// Notes:   scenarios run one after another from reset
`timescale 1ns/1ns
`default_nettype none
module tb;
   import nvc_pkg::*;
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic req_valid_in = 1'b0;
   logic [2:0] req_op_in = 3'h0;
   logic [ADDR_W-1:0] req_addr_in = 17'h00000;
   logic [DATA_W-1:0] req_wdata_in = 8'h00;
   logic req_ready_out, rsp_valid_out, busy_out, store_skipped_out;
   logic [DATA_W-1:0] rsp_rdata_out, host_dq, dev_dq, dq_w;
   logic [ADDR_W-1:0] sram_addr_out;
   logic ce_n, oe_n, we_n, dq_oe_n, store_pin_out, store_pin_oe_n, dev_pull, store_pin_w;
   int errors = 0;
   int comparisons = 0;
   int n, s0;

   assign dq_w = (dq_oe_n === 1'b0) ? host_dq : dev_dq;
   assign store_pin_w = (store_pin_oe_n === 1'b0 || dev_pull === 1'b1) ? 1'b0 : 1'b1;

   always #25 clock_in = ~clock_in;

   nvc_host #(.STORE_CYC(50)) nvc_host_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_op_in(req_op_in),
      .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .rsp_valid_out(rsp_valid_out),
      .rsp_rdata_out(rsp_rdata_out), .busy_out(busy_out),
      .store_skipped_out(store_skipped_out), .sram_addr_out(sram_addr_out),
      .sram_ce_n_out(ce_n), .sram_oe_n_out(oe_n), .sram_we_n_out(we_n), .sram_dq_in(dq_w),
      .sram_dq_out(host_dq), .sram_dq_oe_n_out(dq_oe_n), .hw_store_busy_n_in(store_pin_w),
      .hw_store_busy_n_out(store_pin_out), .hw_store_busy_n_oe_n_out(store_pin_oe_n));

   nvc_dev_model nvc_dev_model_i (.addr_in(sram_addr_out), .ce_n_in(ce_n), .oe_n_in(oe_n),
      .we_n_in(we_n), .dq_in(dq_w), .dq_out(dev_dq), .store_pin_in(store_pin_w),
      .store_pin_pull_out(dev_pull));

   task automatic print_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      comparisons++;
      if (!ok)
      begin
         errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   // called at a clock edge; returns at an edge, cycles to answer in cyc
   task automatic do_req(input logic [2:0] op, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output int cyc);
      req_valid_in <= 1'b1;
      req_op_in <= op;
      req_addr_in <= a;
      req_wdata_in <= d;
      @(posedge clock_in);
      req_valid_in <= 1'b0;
      cyc = 0;
      #1;
      check(busy_out === 1'b1 && req_ready_out === 1'b0, "request not held off");
      while (cyc < 5000)
      begin
         if (rsp_valid_out === 1'b1) break;
         cyc++;
         @(posedge clock_in);
         #1;
      end
      check(cyc < 5000, "no answer");
      @(posedge clock_in);
   endtask

   task automatic t_reset();
      #1;
      check(req_ready_out === 1'b1 && busy_out === 1'b0, "not idle after reset");
      check(ce_n === 1'b1 && oe_n === 1'b1 && we_n === 1'b1, "strobes not idle");
      check(dq_oe_n === 1'b1 && store_pin_w === 1'b1, "pins not released");
      check(store_pin_out === 1'b0, "store pin drive level not low");
      @(posedge clock_in);
   endtask

   task automatic t_rw();
      do_req(OP_WRITE, 17'h00100, 8'hA5, n);
      check(nvc_dev_model_i.mem[17'h00100] === 8'hA5, "write lost");
      do_req(OP_READ, 17'h00100, 8'h00, n);
      check(rsp_rdata_out === 8'hA5, "read data wrong");
   endtask

   task automatic t_soft_store();
      do_req(OP_WRITE, 17'h00200, 8'h3C, n);
      s0 = nvc_dev_model_i.stores;
      do_req(OP_SOFT_STORE, 17'h00000, 8'h00, n);
      check(n >= SOFT_CYC, "soft store answered early");
      check(store_skipped_out === 1'b0, "store flagged skipped");
      check(nvc_dev_model_i.stores == s0 + 1, "soft store not seen");
      check(nvc_dev_model_i.nv[17'h00200] === 8'h3C, "stored byte wrong");
   endtask

   task automatic t_skip();
      s0 = nvc_dev_model_i.stores;
      do_req(OP_SOFT_STORE, 17'h00000, 8'h00, n);
      check(store_skipped_out === 1'b1, "clean store not skipped");
      check(nvc_dev_model_i.stores == s0, "clean store ran");
   endtask

   task automatic t_recall();
      do_req(OP_WRITE, 17'h00200, 8'h11, n);
      s0 = nvc_dev_model_i.recalls;
      do_req(OP_SOFT_RECALL, 17'h00000, 8'h00, n);
      check(nvc_dev_model_i.recalls == s0 + 1, "recall not seen");
      do_req(OP_READ, 17'h00200, 8'h00, n);
      check(rsp_rdata_out === 8'h3C, "recalled byte wrong");
      check(store_skipped_out === 1'b0, "skip flag stuck");
   endtask

   task automatic t_hw();
      do_req(OP_WRITE, 17'h00300, 8'h77, n);
      s0 = nvc_dev_model_i.stores;
      do_req(OP_HW_STORE, 17'h00000, 8'h00, n);
      check(n >= DRAIN_CYC, "store pin answered before drain");
      check(nvc_dev_model_i.stores == s0 + 1, "pin store not seen");
      check(nvc_dev_model_i.nv[17'h00300] === 8'h77, "pin store byte wrong");
      do_req(OP_HW_STORE, 17'h00000, 8'h00, n);
      check(store_skipped_out === 1'b1, "clean pin store not skipped");
      check(nvc_dev_model_i.stores == s0 + 1, "clean pin store ran");
   endtask

   initial
   begin
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      t_reset();
      t_rw();
      t_soft_store();
      t_skip();
      t_recall();
      t_hw();
      check(nvc_dev_model_i.errs == 0, "pin protocol fault");
      print_verdict();
   end

   initial
   begin
      #(40000 * 50);
      errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule // tb
`default_nettype wire
